// >>> pkg/motor_cmd_pkg.sv
// Purpose: constants for the speed and torque command block
// Assumes: 10 MHz clock, 16-bit register port, analog input in millivolts
// Notes: speed in r/min, torque in percent, ramp times in 0.1 s units
// Overview of operation
// - analog speed equals gain times volts
// - signed speed offset added, -2000 to 2000
// - speed command above upper limit only when lower limit exceeds it
// - speed command below lower limit only when upper limit is lower
// - torque limit capped at 300 percent
// - source selection 3 takes analog torque
// - enable input on applies limit, else peak
// - unassigned enable on; several need all
// - clamped output when torque reaches limit
// - analog torque gain percent per volt
// - signed torque offset added, -150 to 150
// - analog torque limit clamped to maximum
// - acceleration time is zero to 3000 r/min
// - deceleration time is 3000 r/min to zero
// - ramps above 0.1 s finish on time
// - direction parameter picks positive rotation sense
// - local standstill blinks direction, key toggles
// - four select inputs choose sixteen data sets
// - data number is binary select value
// - run with selected set's four values
// - select, start with run, stop same input
package motor_cmd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] A_SPD_GAIN = 8'h00;
  localparam logic [7:0] A_SPD_OFS  = 8'h01;
  localparam logic [7:0] A_SPD_UP   = 8'h02;
  localparam logic [7:0] A_SPD_LO   = 8'h03;
  localparam logic [7:0] A_TQ_GAIN  = 8'h04;
  localparam logic [7:0] A_TQ_OFS   = 8'h05;
  localparam logic [7:0] A_TQ_MAX   = 8'h06;
  localparam logic [7:0] A_SRC_SEL  = 8'h07;
  localparam logic [7:0] A_CTRL     = 8'h08;
  localparam logic [7:0] A_ST_SPEED = 8'h09;
  localparam logic [7:0] A_ST_TQLIM = 8'h0A;
  localparam logic [7:0] A_ST_FLAGS = 8'h0B;
  localparam logic [7:0] A_DS_BASE  = 8'h40;
  localparam int CTRL_DIR = 0;
  localparam int CTRL_3WIRE = 1;
  localparam int CTRL_TLMASK = 2;
  localparam logic [15:0] RST_SPD_GAIN = 16'h0352;
  localparam logic [15:0] RST_SPD_OFS  = 16'h0000;
  localparam logic [15:0] RST_SPD_UP   = 16'h0FA0;
  localparam logic [15:0] RST_SPD_LO   = 16'h0032;
  localparam logic [15:0] RST_TQ_GAIN  = 16'h0041;
  localparam logic [15:0] RST_TQ_OFS   = 16'h0000;
  localparam logic [15:0] RST_TQ_MAX   = 16'h012C;
  localparam logic [15:0] RST_SRC_SEL  = 16'h0000;
  localparam logic [15:0] RST_CTRL     = 16'h0001;
  localparam logic [15:0] RST_DS_SPEED = 16'h0032;
  localparam logic [15:0] RST_DS_TQ    = 16'h012C;
  localparam logic [15:0] RST_DS_TIME  = 16'h0005;
  localparam int F_SPEED = 0;
  localparam int F_TQ = 1;
  localparam int F_ACC = 2;
  localparam int F_DEC = 3;
  localparam logic [1:0] SRC_TQ_ANALOG = 2'h3;
  localparam logic [1:0] SRC_SPD_DATA1 = 2'h1;
  localparam logic [1:0] SRC_SPD_ALL = 2'h2;
  localparam logic [15:0] TORQUE_PEAK = 16'h012C;
  localparam int MV_PER_V = 1000;
  localparam int CLK_HZ = 10_000_000;
  localparam int RATED_RPM = 3000;
  localparam int TENTH_S_CYC = CLK_HZ / 10;
  localparam int RAMP_CYC_RPM = TENTH_S_CYC / RATED_RPM;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
endpackage : motor_cmd_pkg

// >>> logic/data_set_mem.sv
// Purpose: sixteen operation data sets, four 16-bit fields each
// Assumes: one shared write port with field select, registered read by entry
// Notes: fields hold speed, torque limit, accel and decel time
`timescale 1ns/1ns
`default_nettype none
module data_set_mem (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // write side
  input  wire logic        wrEn,
  input  wire logic [3:0]  wrEntry,
  input  wire logic [1:0]  wrField,
  input  wire logic [15:0] wrData,
  // read side
  input  wire logic [3:0]  rdEntry,
  output logic      [63:0] rdData
);
  logic [63:0] mem_r [16];

  generate
    for (genvar i = 0; i < 16; i++) begin : g_entry
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mem_r[i] <= {motor_cmd_pkg::RST_DS_TIME, motor_cmd_pkg::RST_DS_TIME,
                       motor_cmd_pkg::RST_DS_TQ, motor_cmd_pkg::RST_DS_SPEED};
        end else if (wrEn && wrEntry == 4'(i)) begin
          mem_r[i][16*wrField +: 16] <= wrData;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 64'h0000_0000_0000_0000;
    end else begin
      rdData <= mem_r[rdEntry];
    end
  end
endmodule : data_set_mem
`default_nettype wire

// >>> logic/motor_speed_torque_command.sv
// Purpose: speed command, torque limit, ramps, direction, data select
// Assumes: inputs synchronous to clock, analog level in millivolts
// Notes: speed held as magnitude plus direction; reversal ramps via zero
`timescale 1ns/1ns
`default_nettype none
module motor_speed_torque_command #(
  parameter int RAMP_CYC = motor_cmd_pkg::RAMP_CYC_RPM,
  parameter int BLINK_CYC = motor_cmd_pkg::BLINK_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // io connector inputs
  input  wire logic        forward_run_in,
  input  wire logic        backward_run_in,
  input  wire logic        direction_select_in,
  input  wire logic [3:0]  data_select_bits,
  input  wire logic [1:0]  torque_limit_enable_in,
  // analog setting and motor feedback
  input  wire logic [13:0] analogMv,
  input  wire logic [15:0] motorTorque,
  // local panel
  input  wire logic        localMode,
  input  wire logic        localRun,
  input  wire logic        dirKey,
  // outputs
  output logic      [15:0] speedCmd,
  output logic             rotateCw,
  output logic      [15:0] torqueLimit,
  output logic             torque_clamped_out,
  output logic             dirBlink,
  output logic      [3:0]  dataNumber
);
  typedef enum logic [1:0] {MS_IDLE, MS_RUN, MS_STOP} motion_t;

  logic [15:0] spdGain_r, spdOfs_r, spdUp_r, spdLo_r;
  logic [15:0] tqGain_r, tqOfs_r, tqMax_r, srcSel_r, ctrl_r;
  motion_t     state_r, state_nxt;
  logic [15:0] speed_r, speed_nxt;
  logic        curPos_r, curPos_nxt;
  logic [21:0] rampCnt_r;
  logic        localDir_r;
  logic [23:0] blinkCnt_r;
  logic        blink_r;
  logic [63:0] dsData;

  // register decode
  wire        dsWrite = regWr && regAddr[7:6] == motor_cmd_pkg::A_DS_BASE[7:6];
  wire [3:0]  dsEntry = regAddr[5:2];
  wire [1:0]  dsField = regAddr[1:0];

  data_set_mem u_mem (
    .clock   (clock),
    .rst_n   (rst_n),
    .wrEn    (dsWrite),
    .wrEntry (dsEntry),
    .wrField (dsField),
    .wrData  (regWrData),
    .rdEntry (dataNumber),
    .rdData  (dsData)
  );

  // selected data set
  assign dataNumber = data_select_bits;
  wire [15:0] dsSpeed = dsData[16*motor_cmd_pkg::F_SPEED +: 16];
  wire [15:0] dsTq    = dsData[16*motor_cmd_pkg::F_TQ +: 16];
  wire [15:0] dsAcc   = dsData[16*motor_cmd_pkg::F_ACC +: 16];
  wire [15:0] dsDec   = dsData[16*motor_cmd_pkg::F_DEC +: 16];

  // analog speed: gain per volt times volts plus offset
  wire [29:0] spdProd = 30'(spdGain_r) * 30'(analogMv);
  wire [17:0] spdScaled = 18'(spdProd / 30'(motor_cmd_pkg::MV_PER_V));
  wire signed [18:0] spdSum = $signed({1'b0, spdScaled}) + 19'(signed'(spdOfs_r));
  wire [1:0]  srcSel = srcSel_r[1:0];
  wire        spdAnalog = srcSel == motor_cmd_pkg::SRC_SPD_ALL ||
                          (srcSel == motor_cmd_pkg::SRC_SPD_DATA1 && dataNumber == 4'h1);
  // signed compares, so a negative sum lands on the lower limit
  wire signed [18:0] spdRaw = spdAnalog ? spdSum : $signed({3'b000, dsSpeed});
  wire signed [18:0] spdUpS = $signed({3'b000, spdUp_r});
  wire signed [18:0] spdLoS = $signed({3'b000, spdLo_r});
  wire [15:0] spdHi = spdRaw > spdUpS ? spdUp_r : 16'(spdRaw);
  wire [15:0] spdCmdVal = spdRaw < spdLoS ? spdLo_r : spdHi;

  // analog torque: gain per volt times volts plus offset, then clamp
  wire [29:0] tqProd = 30'(tqGain_r) * 30'(analogMv);
  wire [17:0] tqScaled = 18'(tqProd / 30'(motor_cmd_pkg::MV_PER_V));
  wire signed [18:0] tqSum = $signed({1'b0, tqScaled}) + 19'(signed'(tqOfs_r));
  wire [15:0] tqPos = tqSum < 0 ? 16'h0000 : (tqSum > 19'h0_FFFF ? 16'hFFFF : 16'(tqSum));
  wire [15:0] tqAnalog = tqPos > tqMax_r ? tqMax_r : tqPos;
  wire [15:0] tqSet = (srcSel == motor_cmd_pkg::SRC_TQ_ANALOG) ? tqAnalog : dsTq;
  wire [15:0] tqCapped = tqSet > motor_cmd_pkg::TORQUE_PEAK ? motor_cmd_pkg::TORQUE_PEAK : tqSet;

  // enable: unassigned terminals count as on, assigned ones must all be on
  wire [1:0]  enMask = ctrl_r[motor_cmd_pkg::CTRL_TLMASK +: 2];
  wire        limitOn = &(torque_limit_enable_in | ~enMask);
  assign torqueLimit = limitOn ? tqCapped : motor_cmd_pkg::TORQUE_PEAK;
  assign torque_clamped_out = motorTorque >= torqueLimit;

  // run and direction request
  wire threeWire = ctrl_r[motor_cmd_pkg::CTRL_3WIRE];
  wire dirParam  = ctrl_r[motor_cmd_pkg::CTRL_DIR];
  wire twoRun = forward_run_in ^ backward_run_in;
  wire runExt = threeWire ? forward_run_in : twoRun;
  wire posExt = threeWire ? !direction_select_in : forward_run_in;
  wire runReq = localMode ? localRun : runExt;
  wire posReq = localMode ? localDir_r : posExt;

  // motion control
  wire [15:0] target = (state_r == MS_RUN && posReq == curPos_r) ? spdCmdVal : 16'h0000;
  wire        accel = target > speed_r;
  wire [21:0] stepLim = 22'(accel ? dsAcc : dsDec) * 22'(RAMP_CYC);
  wire        stepNow = rampCnt_r >= stepLim;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MS_IDLE: begin
        if (runReq) begin
          state_nxt = MS_RUN;
        end
      end
      MS_RUN: begin
        if (!runReq) begin
          state_nxt = MS_STOP;
        end
      end
      MS_STOP: begin
        if (runReq) begin
          state_nxt = MS_RUN;
        end else if (speed_r == 16'h0000) begin
          state_nxt = MS_IDLE;
        end
      end
      default: state_nxt = MS_IDLE;
    endcase
  end

  always_comb begin
    speed_nxt = speed_r;
    curPos_nxt = curPos_r;
    if (speed_r == 16'h0000 && state_r == MS_RUN) begin
      curPos_nxt = posReq;
    end
    if (stepNow && target != speed_r) begin
      speed_nxt = accel ? speed_r + 16'h0001 : speed_r - 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MS_IDLE;
      speed_r <= 16'h0000;
      curPos_r <= 1'b1;
      rampCnt_r <= 22'h00_0000;
    end else begin
      state_r <= state_nxt;
      speed_r <= speed_nxt;
      curPos_r <= curPos_nxt;
      rampCnt_r <= (stepNow || target == speed_r) ? 22'h00_0000 : rampCnt_r + 22'h00_0001;
    end
  end

  assign speedCmd = speed_r;
  assign rotateCw = curPos_r ? dirParam : !dirParam;

  // local panel direction and blink
  wire standstill = speed_r == 16'h0000 && state_r == MS_IDLE;
  wire blinkTick = blinkCnt_r == 24'(BLINK_CYC - 1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      localDir_r <= 1'b1;
      blinkCnt_r <= 24'h00_0000;
      blink_r <= 1'b0;
    end else begin
      if (localMode && standstill && dirKey) begin
        localDir_r <= !localDir_r;
      end
      blinkCnt_r <= blinkTick ? 24'h00_0000 : blinkCnt_r + 24'h00_0001;
      if (blinkTick) begin
        blink_r <= !blink_r;
      end
    end
  end

  assign dirBlink = localMode && standstill && blink_r;

  // register writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      spdGain_r <= motor_cmd_pkg::RST_SPD_GAIN;
      spdOfs_r <= motor_cmd_pkg::RST_SPD_OFS;
      spdUp_r <= motor_cmd_pkg::RST_SPD_UP;
      spdLo_r <= motor_cmd_pkg::RST_SPD_LO;
      tqGain_r <= motor_cmd_pkg::RST_TQ_GAIN;
      tqOfs_r <= motor_cmd_pkg::RST_TQ_OFS;
      tqMax_r <= motor_cmd_pkg::RST_TQ_MAX;
      srcSel_r <= motor_cmd_pkg::RST_SRC_SEL;
      ctrl_r <= motor_cmd_pkg::RST_CTRL;
    end else if (regWr) begin
      case (regAddr)
        motor_cmd_pkg::A_SPD_GAIN: spdGain_r <= regWrData;
        motor_cmd_pkg::A_SPD_OFS:  spdOfs_r <= regWrData;
        motor_cmd_pkg::A_SPD_UP:   spdUp_r <= regWrData;
        motor_cmd_pkg::A_SPD_LO:   spdLo_r <= regWrData;
        motor_cmd_pkg::A_TQ_GAIN:  tqGain_r <= regWrData;
        motor_cmd_pkg::A_TQ_OFS:   tqOfs_r <= regWrData;
        motor_cmd_pkg::A_TQ_MAX:   tqMax_r <= regWrData;
        motor_cmd_pkg::A_SRC_SEL:  srcSel_r <= regWrData;
        motor_cmd_pkg::A_CTRL:     ctrl_r <= regWrData;
        default: ;
      endcase
    end
  end

  // register reads, one cycle later
  logic [15:0] rdMux;
  always_comb begin
    case (regAddr)
      motor_cmd_pkg::A_SPD_GAIN: rdMux = spdGain_r;
      motor_cmd_pkg::A_SPD_OFS:  rdMux = spdOfs_r;
      motor_cmd_pkg::A_SPD_UP:   rdMux = spdUp_r;
      motor_cmd_pkg::A_SPD_LO:   rdMux = spdLo_r;
      motor_cmd_pkg::A_TQ_GAIN:  rdMux = tqGain_r;
      motor_cmd_pkg::A_TQ_OFS:   rdMux = tqOfs_r;
      motor_cmd_pkg::A_TQ_MAX:   rdMux = tqMax_r;
      motor_cmd_pkg::A_SRC_SEL:  rdMux = srcSel_r;
      motor_cmd_pkg::A_CTRL:     rdMux = ctrl_r;
      motor_cmd_pkg::A_ST_SPEED: rdMux = speed_r;
      motor_cmd_pkg::A_ST_TQLIM: rdMux = torqueLimit;
      motor_cmd_pkg::A_ST_FLAGS: rdMux = {9'h000, dataNumber, curPos_r,
                                          state_r != MS_IDLE, torque_clamped_out};
      default: rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= regRd ? rdMux : 16'h0000;
    end
  end

  // checks
  a_upper_clamp: assert property (@(posedge clock) disable iff (!rst_n)
    spdCmdVal <= spdUp_r || spdCmdVal == spdLo_r) else $error("speed above upper limit");
  a_lower_clamp: assert property (@(posedge clock) disable iff (!rst_n)
    spdCmdVal >= spdLo_r) else $error("speed below lower limit");
  a_torque_cap: assert property (@(posedge clock) disable iff (!rst_n)
    limitOn |-> torqueLimit <= motor_cmd_pkg::TORQUE_PEAK) else $error("torque over cap");
  a_limit_off_peak: assert property (@(posedge clock) disable iff (!rst_n)
    !limitOn |-> torqueLimit == motor_cmd_pkg::TORQUE_PEAK) else $error("limit not peak");
  a_limit_unassigned: assert property (@(posedge clock) disable iff (!rst_n)
    enMask == 2'b00 |-> limitOn) else $error("unassigned enable off");
  a_clamp_flag: assert property (@(posedge clock) disable iff (!rst_n)
    torque_clamped_out == (motorTorque >= torqueLimit)) else $error("clamped flag wrong");
  a_analog_max: assert property (@(posedge clock) disable iff (!rst_n)
    srcSel == motor_cmd_pkg::SRC_TQ_ANALOG |-> tqSet <= tqMax_r) else $error("analog tq max");
  a_ramp_linear: assert property (@(posedge clock) disable iff (!rst_n)
    speed_r == $past(speed_r) || speed_r == $past(speed_r) + 16'h0001 ||
    speed_r == $past(speed_r) - 16'h0001) else $error("speed jumped");
  sequence s_run_drop;
    state_r == MS_RUN && runReq ##1 !runReq;
  endsequence
  a_stop_decel: assert property (@(posedge clock) disable iff (!rst_n)
    s_run_drop |=> state_r == MS_STOP) else $error("stop not entered");
  a_data_select: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> dsData == $past(u_mem.mem_r[data_select_bits])) else $error("wrong data set");
endmodule : motor_speed_torque_command
`default_nettype wire

// >>> verif/ctrl_model.sv
// Purpose: external controller model for run, select and analog lines
// Assumes: every line changes just after a rising clock edge
// Notes: HOLD_CYC stands for the minimum hold, shortened in the bench
`timescale 1ns/1ns
`default_nettype none
module ctrl_model #(
  parameter int HOLD_CYC = 100_000
) (
  // clock
  input  wire logic        clock,
  // run and select lines
  output logic             forward_run_in,
  output logic             backward_run_in,
  output logic             direction_select_in,
  output logic      [3:0]  data_select_bits,
  output logic      [1:0]  torque_limit_enable_in,
  // analog level and torque feedback
  output logic      [13:0] analogMv,
  output logic      [15:0] motorTorque
);
  initial begin
    forward_run_in = 1'b0;
    backward_run_in = 1'b0;
    direction_select_in = 1'b0;
    data_select_bits = 4'h0;
    torque_limit_enable_in = 2'h0;
    analogMv = 14'h0000;
    motorTorque = 16'h0000;
  end
  task automatic hold_wait();
    repeat (HOLD_CYC) @(posedge clock);
  endtask : hold_wait
  task automatic select(input logic [3:0] num);
    @(posedge clock);
    data_select_bits <= num;
    hold_wait();
  endtask : select
  task automatic start(input logic back, input logic dirIn);
    @(posedge clock);
    direction_select_in <= dirIn;
    if (back) backward_run_in <= 1'b1;
    else forward_run_in <= 1'b1;
    hold_wait();
  endtask : start
  task automatic stop();
    @(posedge clock);
    forward_run_in <= 1'b0;
    backward_run_in <= 1'b0;
    hold_wait();
  endtask : stop
  task automatic set_in(input logic [13:0] mv, input logic [15:0] tq, input logic [1:0] en);
    @(posedge clock);
    analogMv <= mv;
    motorTorque <= tq;
    torque_limit_enable_in <= en;
  endtask : set_in
endmodule : ctrl_model
`default_nettype wire

// >>> verif/motor_speed_torque_command_tb.sv
// Purpose: bench for the speed and torque command block
// Assumes: short ramp, blink and hold counts
// Notes: register reads are checked from a queue of notes
`timescale 1ns/1ns
`default_nettype none
module motor_speed_torque_command_tb;
  logic        clock, rst_n, regWr, regRd, rdSeen;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData, speedCmd, torqueLimit, motorTorque;
  logic        forward_run_in, backward_run_in, direction_select_in;
  logic [3:0]  data_select_bits, dataNumber;
  logic [1:0]  torque_limit_enable_in;
  logic [13:0] analogMv;
  logic        localMode, localRun, dirKey;
  logic        rotateCw, torque_clamped_out, dirBlink;
  logic [15:0] expQ[$];
  int          num_errors, cmp_count, e, tog;
  logic [13:0] mv;
  logic [31:0] seedVal;
  logic [15:0] rstVal [9];
  ctrl_model #(.HOLD_CYC(20)) ctl (.clock(clock), .forward_run_in(forward_run_in),
    .backward_run_in(backward_run_in), .direction_select_in(direction_select_in),
    .data_select_bits(data_select_bits), .torque_limit_enable_in(torque_limit_enable_in),
    .analogMv(analogMv), .motorTorque(motorTorque));
  motor_speed_torque_command #(.RAMP_CYC(1), .BLINK_CYC(4)) DUT (.clock(clock),
    .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .forward_run_in(forward_run_in), .backward_run_in(backward_run_in),
    .direction_select_in(direction_select_in), .data_select_bits(data_select_bits),
    .torque_limit_enable_in(torque_limit_enable_in), .analogMv(analogMv),
    .motorTorque(motorTorque), .localMode(localMode), .localRun(localRun), .dirKey(dirKey),
    .speedCmd(speedCmd), .rotateCw(rotateCw), .torqueLimit(torqueLimit),
    .torque_clamped_out(torque_clamped_out), .dirBlink(dirBlink), .dataNumber(dataNumber));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // the cycle after a read strobe carries the answer
  always @(negedge clock) begin
    if (rdSeen && expQ.size() > 0) check("read data", regRdData, expQ.pop_front());
    rdSeen = (regRd === 1'b1);
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(exp);
    @(posedge clock);
    regRd <= 1'b0;
  endtask : rd
  task automatic settle();
    @(negedge clock);
    @(negedge clock);
  endtask : settle
  task automatic wait_speed(input logic [15:0] tgt);
    int n;
    n = 0;
    while (speedCmd !== tgt && n < 20000) begin
      @(negedge clock);
      n++;
    end
    repeat (5) @(negedge clock);
    check("speed", speedCmd, tgt);
  endtask : wait_speed
  task automatic step_gap(input int gap, input logic [15:0] dlt);
    logic [15:0] s0;
    int n;
    @(negedge clock);
    s0 = speedCmd;
    n = 0;
    while (speedCmd === s0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    s0 = speedCmd;
    n = 0;
    while (speedCmd === s0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check("step gap", 16'(n), 16'(gap));
    check("step size", speedCmd - s0, dlt);
  endtask : step_gap
  initial begin
    #5_000_000;
    num_errors++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    {regWr, regRd, rdSeen, localMode, localRun, dirKey} = 6'h00;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    seedVal = $urandom(32'hae14_0a06);
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rstVal = '{motor_cmd_pkg::RST_SPD_GAIN,
      motor_cmd_pkg::RST_SPD_OFS, motor_cmd_pkg::RST_SPD_UP, motor_cmd_pkg::RST_SPD_LO,
      motor_cmd_pkg::RST_TQ_GAIN, motor_cmd_pkg::RST_TQ_OFS, motor_cmd_pkg::RST_TQ_MAX,
      motor_cmd_pkg::RST_SRC_SEL, motor_cmd_pkg::RST_CTRL};
    for (int i = 0; i < 9; i++) rd(8'(i), rstVal[i]);
    wr(8'h30, 16'($urandom));
    rd(8'h30, 16'h0000);
    settle();
    check("reset limit", torqueLimit, 16'h012C);
    check("reset dir", 16'(rotateCw), 16'h0001);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      ctl.select(4'(i));
      check("data number", 16'(dataNumber), 16'(i));
    end
    ctl.select(4'h0);
    $display("test select done");
    wr(8'h41, 16'h0064);
    ctl.set_in(14'h0000, 16'h0064, 2'h0);
    settle();
    check("tq limit", torqueLimit, 16'h0064);
    check("clamped", 16'(torque_clamped_out), 16'h0001);
    ctl.set_in(14'h0000, 16'h0063, 2'h1);
    settle();
    check("unclamped", 16'(torque_clamped_out), 16'h0000);
    wr(motor_cmd_pkg::A_CTRL, 16'h000D);
    settle();
    check("tq peak", torqueLimit, motor_cmd_pkg::TORQUE_PEAK);
    ctl.set_in(14'h0000, 16'h0063, 2'h3);
    settle();
    check("tq all on", torqueLimit, 16'h0064);
    wr(motor_cmd_pkg::A_CTRL, 16'h0001);
    wr(motor_cmd_pkg::A_SRC_SEL, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      mv = 14'($urandom % 5000);
      e = 65 * mv / 1000;
      if (e > 300) e = 300;
      ctl.set_in(mv, 16'h0000, 2'h0);
      settle();
      check("tq analog", torqueLimit, 16'(e));
    end
    wr(motor_cmd_pkg::A_TQ_OFS, 16'hFF6A);
    ctl.set_in(14'd1000, 16'h0000, 2'h0);
    settle();
    check("tq negative", torqueLimit, 16'h0000);
    ctl.set_in(14'd4000, 16'h0000, 2'h0);
    settle();
    check("tq offset", torqueLimit, 16'd110);
    wr(motor_cmd_pkg::A_TQ_MAX, 16'd200);
    ctl.set_in(14'd10000, 16'h0000, 2'h0);
    settle();
    check("tq max", torqueLimit, 16'd200);
    wr(motor_cmd_pkg::A_SRC_SEL, 16'h0000);
    $display("test torque done");
    wr(8'h40, 16'd100);
    wr(8'h42, 16'h0001);
    wr(8'h43, 16'h0002);
    ctl.start(1'b0, 1'b0);
    step_gap(2, 16'h0001);
    wait_speed(16'd100);
    check("dir forward", 16'(rotateCw), 16'h0001);
    rd(motor_cmd_pkg::A_ST_SPEED, 16'd100);
    ctl.stop();
    step_gap(3, 16'hFFFF);
    wait_speed(16'h0000);
    $display("test ramp done");
    wr(8'h42, 16'h0000);
    wr(8'h43, 16'h0000);
    wr(motor_cmd_pkg::A_SRC_SEL, 16'h0002);
    wr(motor_cmd_pkg::A_SPD_OFS, 16'hFF38);
    wr(motor_cmd_pkg::A_SPD_UP, 16'd1000);
    ctl.set_in(14'd2000, 16'h0000, 2'h0);
    ctl.start(1'b0, 1'b0);
    wait_speed(16'd1000);
    ctl.set_in(14'd0, 16'h0000, 2'h0);
    wait_speed(16'd50);
    wr(motor_cmd_pkg::A_SPD_UP, 16'd4000);
    ctl.set_in(14'd1000, 16'h0000, 2'h0);
    wait_speed(16'd650);
    wr(motor_cmd_pkg::A_SRC_SEL, 16'h0001);
    wait_speed(16'd100);
    ctl.select(4'h1);
    wait_speed(16'd650);
    ctl.select(4'h0);
    ctl.stop();
    wait_speed(16'h0000);
    wr(motor_cmd_pkg::A_CTRL, 16'h0000);
    ctl.start(1'b1, 1'b0);
    check("dir back", 16'(rotateCw), 16'h0001);
    ctl.stop();
    wait_speed(16'h0000);
    wr(motor_cmd_pkg::A_CTRL, 16'h0003);
    ctl.start(1'b0, 1'b1);
    check("dir 3wire", 16'(rotateCw), 16'h0000);
    ctl.stop();
    wait_speed(16'h0000);
    $display("test speed done");
    @(posedge clock);
    localMode <= 1'b1;
    ctl.start(1'b0, 1'b0);
    check("local ignores run", speedCmd, 16'h0000);
    tog = 0;
    @(negedge clock);
    e = dirBlink;
    // blink toggles every 4 cycles, so 40 cycles hold exactly 10 toggles
    repeat (40) begin
      @(negedge clock);
      if (dirBlink !== 1'(e)) tog++;
      e = dirBlink;
    end
    check("blink", 16'(tog), 16'd10);
    @(posedge clock);
    dirKey <= 1'b1;
    @(posedge clock);
    dirKey <= 1'b0;
    localRun <= 1'b1;
    repeat (10) @(negedge clock);
    check("local dir", 16'(rotateCw), 16'h0000);
    check("blink off", 16'(dirBlink), 16'h0000);
    @(posedge clock);
    localRun <= 1'b0;
    wait_speed(16'h0000);
    ctl.stop();
    localMode <= 1'b0;
    $display("test local done");
    final_report();
  end
endmodule : motor_speed_torque_command_tb
`default_nettype wire
